/* rtl/spd_decoder.sv */
// simd instruction prefix decoder with fault, fence and register-select outputs
`timescale 1ns/1ps
// Summary of operation
// - lock prefix on simd op faults invalid
// - address/segment prefixes apply only to memory
// - stray repeat/size/hint prefixes flagged reserved
// - mandatory prefix, escape, opcode form opcode
// - misaligned packed integer memory operand faults
// - fence holds later stores until earlier visible
// - 64-bit mode extension reaches eight more registers
// - meaningless extension prefix is ignored
// - wide bit selects 64-bit general registers
// - compatibility mode decodes like protected mode
// - mistyped moves transfer data, only latency
// - no vector flags; compare mask, two bits
// - scalar double compares write integer flags
// - fill hint never commits; a scalar compare still writes flags
// - non-temporal stores bypass cache allocation
// - truncating store ignores rounding field
// - 128-bit integer op doubles 64-bit elements
module spd_decoder
   import spd_pkg::*;
#(
   parameter int MAX_PFX = 4
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // instruction byte stream
   input wire logic byte_valid_i,
   input wire logic [7:0] byte_i,
   input wire logic long_mode_i,
   // memory address of operand and instruction class hints
   input wire logic [3:0] ea_low_i,
   input wire logic is_pint_op_i,
   input wire logic uses_gpr_i,
   input wire logic is_fence_i,
   input wire logic is_nt_store_i,
   input wire logic is_fill_hint_i,
   input wire logic is_scalar_cmp_i,
   input wire logic is_fist_trunc_i,
   input wire logic store_pending_i,
   // decode results
   output logic done_o,
   output logic [7:0] opcode_o,
   output logic [1:0] mpfx_o,
   output logic ud_fault_o,
   output logic gp_fault_o,
   output logic reserved_o,
   output logic mem_operand_o,
   output logic addr_override_o,
   output logic [3:0] dst_reg_o,
   output logic [3:0] src_reg_o,
   output logic gpr_wide_o,
   output logic commit_o,
   output logic cache_alloc_o,
   output logic store_hold_o,
   output logic flags_write_o,
   output logic use_trunc_o
);
   initial begin
      if (MAX_PFX < 1 || MAX_PFX > 14) $error("MAX_PFX out of range");
   end

   typedef struct packed {
      spd_state_t st;
      logic [3:0] npfx;
      logic lock;
      logic adsz;
      logic seg;
      logic stray;
      logic [1:0] mp;
      logic [3:0] rext;
      logic rext_ok;
      logic [7:0] opc;
      logic done;
      logic ud;
      logic gp;
      logic res;
      logic mem;
      logic [3:0] dst;
      logic [3:0] src;
      logic wide;
      logic commit;
      logic alloc;
      logic hold;
      logic flg;
      logic trunc;
      logic ovr;
   } spd_regs_t;

   spd_regs_t s_reg, s_next;

   // class of a prefix byte; used for both mandatory and reserved decisions
   function automatic logic [1:0] mp_of(input logic [7:0] b);
      mp_of = (b == PFX_OPSZ) ? SPD_MP_66 : (b == PFX_REP) ? SPD_MP_F3 :
              (b == PFX_REPNE) ? SPD_MP_F2 : SPD_MP_NONE;
   endfunction

   function automatic logic is_seg(input logic [7:0] b);
      is_seg = (b == PFX_SEG_CS) || (b == PFX_SEG_SS) || (b == PFX_SEG_DS) ||
               (b == PFX_SEG_ES) || (b == PFX_SEG_FS) || (b == PFX_SEG_GS);
   endfunction

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      s_next.commit = 1'b0;
      s_next.flg = 1'b0;
      // fault and reserved flags are pulses that stand only with done
      s_next.ud = 1'b0;
      s_next.gp = 1'b0;
      s_next.res = 1'b0;
      // store ordering: after a fence, hold later stores while earlier ones are in flight
      s_next.hold = (s_reg.hold | is_fence_i) & store_pending_i;
      unique case (s_reg.st)
         SPD_IDLE, SPD_PFX: begin
            if (byte_valid_i) begin
               s_next.st = SPD_PFX;
               // a new instruction starts with no mandatory prefix of its own
               if (s_reg.st == SPD_IDLE) begin
                  s_next.mp = SPD_MP_NONE;
               end
               if (byte_i == PFX_LOCK) begin
                  s_next.lock = 1'b1;
               end else if (byte_i == PFX_ADSZ) begin
                  s_next.adsz = 1'b1;
               end else if (is_seg(byte_i) || byte_i == PFX_HINT_E2 ||
                            byte_i == PFX_HINT_E3) begin
                  // a hint after a segment override must not drop the override
                  s_next.seg = s_reg.seg | is_seg(byte_i);
                  s_next.stray = s_reg.stray | !is_seg(byte_i);
               end else if (mp_of(byte_i) != SPD_MP_NONE) begin
                  // an earlier mandatory candidate becomes a stray prefix
                  s_next.stray = s_reg.stray | (s_reg.st == SPD_PFX &&
                                 s_reg.mp != SPD_MP_NONE);
                  s_next.mp = mp_of(byte_i);
               end else if (long_mode_i && byte_i[7:4] == REXT_HI) begin
                  // compatibility mode takes 4x as an ordinary byte
                  s_next.rext = byte_i[3:0];
                  s_next.rext_ok = 1'b1;
               end else if (byte_i == ESC_BYTE) begin
                  s_next.st = SPD_OPC;
               end else begin
                  s_next.st = SPD_IDLE;
               end
               if (s_reg.npfx == 4'(MAX_PFX) && s_next.st == SPD_PFX) begin
                  s_next.st = SPD_IDLE;
               end
               s_next.npfx = s_reg.npfx + 4'h1;
            end
         end
         SPD_OPC: begin
            if (byte_valid_i) begin
               s_next.opc = byte_i;
               s_next.st = SPD_MODRM;
            end
         end
         SPD_MODRM: begin
            if (byte_valid_i) begin
               s_next.st = SPD_IDLE;
               s_next.done = 1'b1;
               s_next.mem = byte_i[7:6] != 2'b11;
               // extension bits take effect only where a field uses them
               s_next.dst = {s_reg.rext_ok & s_reg.rext[REXT_R_BIT], byte_i[5:3]};
               s_next.src = {s_reg.rext_ok & s_reg.rext[REXT_B_BIT] &
                             (byte_i[7:6] == 2'b11), byte_i[2:0]};
               s_next.wide = uses_gpr_i & s_reg.rext_ok & s_reg.rext[REXT_W_BIT];
               s_next.ud = s_reg.lock;
               s_next.gp = !s_reg.lock && is_pint_op_i && (byte_i[7:6] != 2'b11) &&
                           ((ea_low_i & ALIGN_MASK) != 4'h0);
               // address and segment prefixes are reserved on register forms
               s_next.res = s_reg.stray | ((s_reg.adsz | s_reg.seg) &
                            (byte_i[7:6] == 2'b11));
               // the override reaches addressing only on memory forms
               s_next.ovr = (s_reg.adsz | s_reg.seg) & (byte_i[7:6] != 2'b11);
               // faulting instructions commit nothing
               s_next.commit = !s_reg.lock && !s_next.gp && !is_fill_hint_i;
               s_next.alloc = !is_nt_store_i && !is_fill_hint_i;
               s_next.flg = is_scalar_cmp_i && !s_reg.lock && !s_next.gp;
               s_next.trunc = is_fist_trunc_i;
               s_next.mp = s_reg.mp;
               s_next.npfx = 4'h0;
               s_next.lock = 1'b0;
               s_next.adsz = 1'b0;
               s_next.seg = 1'b0;
               s_next.stray = 1'b0;
               s_next.rext_ok = 1'b0;
            end
         end
      endcase
      if (s_reg.st == SPD_IDLE && !byte_valid_i) begin
         s_next.npfx = 4'h0;
      end
      if (s_reg.st == SPD_PFX && s_next.st == SPD_IDLE) begin
         s_next.npfx = 4'h0;
         s_next.lock = 1'b0;
         s_next.adsz = 1'b0;
         s_next.seg = 1'b0;
         s_next.stray = 1'b0;
         s_next.rext_ok = 1'b0;
         s_next.mp = SPD_MP_NONE;
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ****************************************
   // outputs straight from the state register
   // ****************************************
   // data moves and element-wise ops pass through unchanged; typing is not checked
   // the 128-bit datapath repeats the 64-bit element op on both halves
   // the compare mask goes to a general register; vector state has no flags
   assign done_o = s_reg.done;
   assign opcode_o = s_reg.opc;
   assign mpfx_o = s_reg.mp;
   assign ud_fault_o = s_reg.ud;
   assign gp_fault_o = s_reg.gp;
   assign reserved_o = s_reg.res;
   assign mem_operand_o = s_reg.mem;
   assign addr_override_o = s_reg.ovr;
   assign dst_reg_o = s_reg.dst;
   assign src_reg_o = s_reg.src;
   assign gpr_wide_o = s_reg.wide;
   assign commit_o = s_reg.commit;
   assign cache_alloc_o = s_reg.alloc;
   assign store_hold_o = s_reg.hold;
   assign flags_write_o = s_reg.flg;
   assign use_trunc_o = s_reg.trunc;

   // ****************************************
   // assertions
   // ****************************************
   AST_UD_NO_COMMIT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      ud_fault_o |-> !commit_o) else $error("lock fault committed");
   AST_GP_NO_COMMIT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      gp_fault_o |-> !commit_o && !flags_write_o) else $error("gp fault committed");
   AST_GP_ALIGN: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (s_reg.st == SPD_MODRM && byte_valid_i && !s_reg.lock && is_pint_op_i &&
       byte_i[7:6] != 2'b11 && ea_low_i != 4'h0) |=> gp_fault_o) else $error("no gp");
   AST_LOCK_UD: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (s_reg.st == SPD_MODRM && byte_valid_i && s_reg.lock) |=> ud_fault_o)
      else $error("lock not faulted");
   AST_FENCE_HOLD: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (is_fence_i && store_pending_i) |=> store_hold_o) else $error("fence not held");
   AST_NT_NOALLOC: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (s_reg.st == SPD_MODRM && byte_valid_i && is_nt_store_i) |=> !cache_alloc_o)
      else $error("nt store allocated");
   AST_HINT_NOCOMMIT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (s_reg.st == SPD_MODRM && byte_valid_i && is_fill_hint_i) |=> !commit_o)
      else $error("hint committed");
   // the modrm byte is the last step of every decode; later checks start from it
   sequence s_modrm_taken;
      s_reg.st == SPD_MODRM && byte_valid_i;
   endsequence
   // wide is a level held until the next decode, so it is judged at the decode edge
   AST_WIDE_GPR: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      s_modrm_taken ##0 !uses_gpr_i |=> !gpr_wide_o) else $error("wide without gpr");
   // outside 64-bit mode no extension byte is taken, so nothing reaches the upper bank
   AST_COMPAT_NOEXT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      s_modrm_taken ##0 !long_mode_i |=> !gpr_wide_o && !dst_reg_o[3])
      else $error("extension outside long mode");
   // address and segment prefixes on a register form are reported reserved
   AST_REG_FORM_RES: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      s_modrm_taken ##0 ((s_reg.adsz || s_reg.seg) && byte_i[7:6] == 2'b11) |=> reserved_o)
      else $error("override on register form not reserved");
   AST_OVR_MEM: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      addr_override_o |-> mem_operand_o) else $error("override without memory operand");
   // an earlier size or repeat byte that lost the mandatory role is reserved
   AST_STRAY_RES: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      s_modrm_taken ##0 s_reg.stray |=> reserved_o) else $error("stray prefix not reserved");
   // done is a one-cycle pulse; a level here would double-count decodes
   AST_DONE_PULSE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      done_o |=> !done_o) else $error("done held");
   // fault pulses never appear outside a decode result
   AST_FAULT_DONE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (ud_fault_o || gp_fault_o || reserved_o) |-> done_o) else $error("fault without done");
   // limitation: the hint class is trusted from the fetch side, not decoded here
   // trade-off: per-bank register checks stay in the datapath, not in this decoder
endmodule

/* rtl/spd_pkg.sv */
// constants and types shared by the simd prefix decoder
package spd_pkg;
   // ****************************************
   // prefix and opcode byte values
   // ****************************************
   localparam logic [7:0] PFX_LOCK = 8'hF0;
   localparam logic [7:0] PFX_REPNE = 8'hF2;
   localparam logic [7:0] PFX_REP = 8'hF3;
   localparam logic [7:0] PFX_OPSZ = 8'h66;
   localparam logic [7:0] PFX_ADSZ = 8'h67;
   localparam logic [7:0] PFX_SEG_CS = 8'h2E;
   localparam logic [7:0] PFX_SEG_SS = 8'h36;
   localparam logic [7:0] PFX_SEG_DS = 8'h3E;
   localparam logic [7:0] PFX_SEG_ES = 8'h26;
   localparam logic [7:0] PFX_SEG_FS = 8'h64;
   localparam logic [7:0] PFX_SEG_GS = 8'h65;
   localparam logic [7:0] PFX_HINT_NT = 8'h2E;
   localparam logic [7:0] PFX_HINT_E2 = 8'hE2;
   localparam logic [7:0] PFX_HINT_E3 = 8'hE3;
   localparam logic [7:0] ESC_BYTE = 8'h0F;
   localparam logic [3:0] REXT_HI = 4'h4;
   // ****************************************
   // field positions and alignment
   // ****************************************
   localparam int REXT_W_BIT = 3;
   localparam int REXT_R_BIT = 2;
   localparam int REXT_B_BIT = 0;
   localparam logic [3:0] ALIGN_MASK = 4'hF;
   // ****************************************
   // decoded mandatory prefix class and decoder states
   // ****************************************
   typedef enum logic [1:0] {SPD_MP_NONE, SPD_MP_66, SPD_MP_F3, SPD_MP_F2} spd_mpfx_t;
   typedef enum {SPD_IDLE, SPD_PFX, SPD_OPC, SPD_MODRM} spd_state_t;
endpackage

/* tb/spd_byte_src.sv */
// instruction byte source standing in for the program fetch path
`timescale 1ns/1ps
module spd_byte_src (
   // clock
   input wire logic clk_sys_i,
   // byte stream towards the decoder
   output logic byte_valid_o,
   output logic [7:0] byte_o
);
   // ************
   // stream driver
   // ************
   // quiet bus at time zero
   initial begin
      byte_valid_o = 1'b0;
      byte_o = 8'h00;
   end
   // one byte per call; a slow call idles a cycle first with a scrambled bus
   task automatic put(input logic [7:0] b, input bit slow);
      if (slow) begin
         byte_valid_o = 1'b0;
         byte_o = ~byte_o;
         @(posedge clk_sys_i);
         #1;
      end
      byte_valid_o = 1'b1;
      byte_o = b;
      @(posedge clk_sys_i);
      #1;
   endtask
   // no stale byte left on the bus, so a late sample cannot look valid
   task automatic idle();
      byte_valid_o = 1'b0;
      byte_o = ~byte_o;
   endtask
endmodule

/* tb/testbench.sv */
// self-checking bench for the simd prefix decoder
`timescale 1ns/1ps
module testbench;
   import spd_pkg::*;
   // ************
   // signals
   // ************
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   logic byte_valid_i, long_mode_i, is_pint_op_i, uses_gpr_i, is_fence_i, is_nt_store_i;
   logic is_fill_hint_i, is_scalar_cmp_i, is_fist_trunc_i, store_pending_i;
   logic [7:0] byte_i, opcode_o;
   logic [3:0] ea_low_i, dst_reg_o, src_reg_o;
   logic [1:0] mpfx_o;
   logic done_o, ud_fault_o, gp_fault_o, reserved_o, mem_operand_o, addr_override_o;
   logic gpr_wide_o, commit_o, cache_alloc_o, store_hold_o, flags_write_o, use_trunc_o;
   int seed = 49218;
   int n_mismatch = 0;
   int n_checks = 0;
   logic [7:0] mps[$];
   logic [7:0] mpt[3] = '{PFX_OPSZ, PFX_REP, PFX_REPNE};
   logic [7:0] segs[8] = '{PFX_ADSZ, PFX_SEG_SS, PFX_SEG_ES, PFX_SEG_FS, PFX_SEG_GS,
      PFX_ADSZ, PFX_SEG_SS, PFX_SEG_GS};
   logic [7:0] k_seg, k_hint, k_opc, k_modrm;
   logic [3:0] k_rex;
   bit k_lock, k_rexon, k_slow;
   // 100 MHz clock
   always #5 clk_sys_i = ~clk_sys_i;
   // ************
   // instances
   // ************
   spd_byte_src i_spd_byte_src (.clk_sys_i(clk_sys_i), .byte_valid_o(byte_valid_i),
      .byte_o(byte_i));
   // six prefixes so lock, segment, hint, two mandatory and extension all fit
   spd_decoder #(.MAX_PFX(6)) i_spd_decoder (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .byte_valid_i(byte_valid_i), .byte_i(byte_i), .long_mode_i(long_mode_i),
      .ea_low_i(ea_low_i), .is_pint_op_i(is_pint_op_i), .uses_gpr_i(uses_gpr_i),
      .is_fence_i(is_fence_i), .is_nt_store_i(is_nt_store_i), .is_fill_hint_i(is_fill_hint_i),
      .is_scalar_cmp_i(is_scalar_cmp_i), .is_fist_trunc_i(is_fist_trunc_i),
      .store_pending_i(store_pending_i), .done_o(done_o), .opcode_o(opcode_o), .mpfx_o(mpfx_o),
      .ud_fault_o(ud_fault_o), .gp_fault_o(gp_fault_o), .reserved_o(reserved_o),
      .mem_operand_o(mem_operand_o), .addr_override_o(addr_override_o), .dst_reg_o(dst_reg_o),
      .src_reg_o(src_reg_o), .gpr_wide_o(gpr_wide_o), .commit_o(commit_o),
      .cache_alloc_o(cache_alloc_o), .store_hold_o(store_hold_o),
      .flags_write_o(flags_write_o), .use_trunc_o(use_trunc_o));
   // ************
   // helpers
   // ************
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // verdict and end of run
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // random instruction shape and class hints
   task automatic pick(input bit lng);
      logic [31:0] r;
      logic [31:0] q;
      r = $random(seed);
      q = $random(seed);
      k_lock = r[2:0] == 3'h0;
      k_hint = r[3] ? (r[4] ? PFX_HINT_E3 : PFX_HINT_E2) : 8'h00;
      k_seg = r[5] ? segs[r[8:6]] : 8'h00;
      mps.delete();
      repeat (int'(r[10:9]) % 3) mps.push_back(mpt[$unsigned($random(seed)) % 3]);
      k_rexon = lng & r[11];
      k_rex = r[15:12];
      k_modrm = r[23:16];
      k_opc = r[31:24];
      {is_fist_trunc_i, is_scalar_cmp_i, is_fill_hint_i, is_nt_store_i} = q[3:0];
      {uses_gpr_i, is_pint_op_i, ea_low_i} = q[9:4];
      k_slow = q[10];
      long_mode_i = lng;
   endtask
   // drive one instruction, then compare the done cycle against the model
   task automatic exec();
      logic mem, gp, ok, rsv;
      logic [3:0] src;
      logic [1:0] mp;
      mem = k_modrm[7:6] != 2'b11;
      mp = 2'h0;
      foreach (mps[i]) mp = mps[i] == PFX_OPSZ ? 2'h1 : (mps[i] == PFX_REP ? 2'h2 : 2'h3);
      gp = !k_lock && mem && is_pint_op_i && ea_low_i != 4'h0;
      ok = !k_lock && !gp;
      rsv = mps.size() > 1 || k_hint != 8'h00 || (k_seg != 8'h00 && !mem);
      // the base-extension bit has meaning only for a register form
      src = {k_rexon & k_rex[REXT_B_BIT] & !mem, k_modrm[2:0]};
      if (k_lock) i_spd_byte_src.put(PFX_LOCK, k_slow);
      if (k_seg != 8'h00) i_spd_byte_src.put(k_seg, k_slow);
      if (k_hint != 8'h00) i_spd_byte_src.put(k_hint, k_slow);
      foreach (mps[i]) i_spd_byte_src.put(mps[i], k_slow);
      if (k_rexon) i_spd_byte_src.put({REXT_HI, k_rex}, k_slow);
      i_spd_byte_src.put(ESC_BYTE, k_slow);
      i_spd_byte_src.put(k_opc, k_slow);
      i_spd_byte_src.put(k_modrm, k_slow);
      i_spd_byte_src.idle();
      cmp("done", 8'h01, 8'(done_o));
      cmp("opcode", k_opc, opcode_o);
      cmp("mpfx", 8'(mp), 8'(mpfx_o));
      cmp("ud", 8'(k_lock), 8'(ud_fault_o));
      cmp("gp", 8'(gp), 8'(gp_fault_o));
      cmp("reserved", 8'(rsv), 8'(reserved_o));
      cmp("commit", 8'(ok && !is_fill_hint_i), 8'(commit_o));
      cmp("flags", 8'(ok && is_scalar_cmp_i), 8'(flags_write_o));
      if (ok) begin
         cmp("mem", 8'(mem), 8'(mem_operand_o));
         cmp("addr", 8'(mem && k_seg != 8'h00), 8'(addr_override_o));
         cmp("dst", 8'({k_rexon & k_rex[REXT_R_BIT], k_modrm[5:3]}), 8'(dst_reg_o));
         cmp("src", 8'(src), 8'(src_reg_o));
         cmp("wide", 8'(k_rexon & k_rex[REXT_W_BIT] & uses_gpr_i), 8'(gpr_wide_o));
         cmp("trunc", 8'(is_fist_trunc_i), 8'(use_trunc_o));
         if (is_nt_store_i) cmp("alloc", 8'h00, 8'(cache_alloc_o));
      end
      // one idle edge so the next call does not raise valid in this time step
      @(posedge clk_sys_i);
      #1;
   endtask
   // ************
   // test sequence
   // ************
   initial begin
      {long_mode_i, ea_low_i, is_pint_op_i, uses_gpr_i, is_fence_i} = '0;
      {is_nt_store_i, is_fill_hint_i, is_scalar_cmp_i, is_fist_trunc_i, store_pending_i} = '0;
      repeat (20) @(posedge clk_sys_i);
      #1;
      reset_i = 1'b0;
      for (int i = 0; i < 6; i++) begin
         pick(i[0]);
         k_lock = 1'b1;
         exec();
      end
      $display("lock test done");
      // every low address value on a packed integer memory form
      for (int i = 0; i < 16; i++) begin
         pick(1'b0);
         k_lock = 1'b0;
         k_modrm[7:6] = 2'b10;
         is_pint_op_i = 1'b1;
         ea_low_i = 4'(i);
         exec();
      end
      $display("alignment test done");
      for (int i = 0; i < 3; i++) begin
         pick(1'b1);
         mps = '{mpt[i]};
         exec();
      end
      $display("mandatory prefix test done");
      // mixed traffic, 64-bit mode first, compatibility mode after
      for (int i = 0; i < 120; i++) begin
         pick(i < 70);
         exec();
      end
      $display("random test done");
      pick(1'b1);
      k_lock = 1'b0;
      k_modrm[7:6] = 2'b11;
      store_pending_i = 1'b1;
      is_fence_i = 1'b1;
      exec();
      cmp("hold", 8'h01, 8'(store_hold_o));
      store_pending_i = 1'b0;
      for (int i = 0; i < 4 && store_hold_o !== 1'b0; i++) begin
         @(posedge clk_sys_i);
         #1;
      end
      cmp("release", 8'h00, 8'(store_hold_o));
      is_fence_i = 1'b0;
      $display("fence test done");
      test_done();
   end
   // watchdog far beyond the expected run of about 1300 cycles
   initial begin
      #100000;
      n_mismatch++;
      test_done();
   end
endmodule
